// ---- hw/utmc_pkg.sv ----
/*
 * utmc_pkg: register map, field positions, reset values and carrier types
 * for the test-mode and control-endpoint register block.
 * assumes a 32-bit APB master and a same-clock controller core.
 */
package utmc_pkg;
   // byte addresses of the registers
   localparam logic [7:0] ADDR_TEST_MODE   = 8'h00;
   localparam logic [7:0] ADDR_TX_MAXP     = 8'h04;
   localparam logic [7:0] ADDR_EP0_CSR     = 8'h08;
   localparam logic [7:0] ADDR_INT_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_INT_CLEAR   = 8'h10;
   localparam logic [7:0] ADDR_INT_ENABLE  = 8'h14;
   // test mode control fields
   localparam int TM_SE0_NAK     = 0;
   localparam int TM_DRIVE_J     = 1;
   localparam int TM_DRIVE_K     = 2;
   localparam int TM_TEST_PACKET = 3;
   localparam int TM_HS_OVERRIDE = 4;
   localparam int TM_FS_OVERRIDE = 5;
   localparam int TM_LOOPBACK    = 6;
   localparam int TM_HOST_FORCE  = 7;
   localparam logic [7:0] TEST_MODE_RESET = 8'h00;
   // tx max packet size
   localparam int PAYLOAD_W = 11;
   localparam logic [10:0] PAYLOAD_MAX   = 11'h400;
   localparam logic [10:0] PAYLOAD_RESET = 11'h000;
   // control endpoint status fields
   localparam int CS_RX_PRESENT  = 0;
   localparam int CS_TX_LOADED   = 1;
   localparam int CS_STALL_SENT  = 2;
   localparam int CS_LAST_DATA   = 3;
   localparam int CS_EARLY_END   = 4;
   localparam int CS_STALL_REQ   = 5;
   localparam int CS_RX_ACK      = 6;
   localparam int CS_EARLY_ACK   = 7;
   localparam int CS_FLUSH       = 8;
   // interrupt status fields
   localparam int IRQ_TX_DONE    = 0;
   localparam int IRQ_RX_ARRIVED = 1;
   localparam int IRQ_EARLY_END  = 2;
   localparam int IRQ_STALL_SENT = 3;
   localparam int IRQ_W          = 4;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   // length of the standard test packet in bytes
   localparam logic [5:0] TEST_PACKET_BYTES = 6'h35;

   typedef enum logic [0:0] {SPD_FULL, SPD_HIGH} utmc_speed_type;

   typedef struct packed {
      logic       sessionOn;
      logic       hostDetected;
      logic       busReset;
      logic       hsDetected;
      logic       packetSent;
      logic       packetReceived;
      logic       controlEnded;
      logic       stallSent;
      logic       inToken;
      logic       testByteTaken;
   } utmc_core_in_type;

   typedef struct packed {
      logic       hostRole;
      logic       highSpeed;
      logic       loopbackCopy;
      logic       fifoFlush;
      logic       testPacketOn;
      logic       testPacketRestart;
      logic       driveK;
      logic       driveJ;
      logic       nakAnswer;
      logic       stallHandshake;
      logic [10:0] payloadLimit;
   } utmc_core_out_type;
endpackage

// ---- hw/utmc_test_mode_ctrl.sv ----
/*
 * utmc_test_mode_ctrl: APB register block for the test modes, transmit
 * payload limit and the control endpoint status bits, with interrupts.
 * assumes the core inputs are on clk and event inputs are one-cycle pulses.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module utmc_test_mode_ctrl
   import utmc_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // controller core
   input  wire utmc_core_in_type  coreIn,
   output utmc_core_out_type      coreOut,
   // interrupt
   output logic                   irq
);
   typedef struct packed {
      logic [7:0]      usb_test_mode_control;
      logic            forcedHost;
      logic            hostRole;
      utmc_speed_type  speed;
      logic [10:0]     payload;
      logic            rxPresent;
      logic            txLoaded;
      logic            stallSentFlag;
      logic            lastData;
      logic            earlyEnd;
      logic            stallReq;
      logic [3:0]      irqStatus;
      logic [3:0]      irqEnable;
      logic            loopbackPulse;
      logic            flushPulse;
      logic            nakPulse;
      logic            restartPulse;
      logic [5:0]      byteCount;
      logic [31:0]     rdata;
   } utmc_state_type;

   utmc_state_type st_r;
   utmc_state_type st_nxt;

   function automatic logic mapped(input logic [7:0] a);
      return a == ADDR_TEST_MODE || a == ADDR_TX_MAXP || a == ADDR_EP0_CSR ||
             a == ADDR_INT_STATUS || a == ADDR_INT_CLEAR || a == ADDR_INT_ENABLE;
   endfunction

   logic wrAcc;
   logic rdSetup;
   logic csrWr;
   logic [31:0] rdVal;

   assign wrAcc   = psel && penable && pwrite && mapped(paddr);
   assign rdSetup = psel && !penable && !pwrite;
   assign csrWr   = wrAcc && paddr == ADDR_EP0_CSR;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);

   always_comb begin
      rdVal = 32'h0000_0000;
      unique case (paddr)
         // loopback bit is write-only, reads as zero
         ADDR_TEST_MODE:  rdVal = {24'h00_0000, st_r.usb_test_mode_control & ~(8'h01 << TM_LOOPBACK)};
         ADDR_TX_MAXP:    rdVal = {21'h00_0000, st_r.payload};
         ADDR_EP0_CSR:    rdVal = {27'h000_0000, st_r.earlyEnd, 1'b0, st_r.stallSentFlag,
                                   st_r.txLoaded, st_r.rxPresent};
         ADDR_INT_STATUS: rdVal = {28'h000_0000, st_r.irqStatus};
         ADDR_INT_ENABLE: rdVal = {28'h000_0000, st_r.irqEnable};
         default:         rdVal = 32'h0000_0000;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.loopbackPulse = 1'b0;
      st_nxt.flushPulse    = 1'b0;
      st_nxt.nakPulse      = 1'b0;
      st_nxt.restartPulse  = 1'b0;
      if (rdSetup) begin
         st_nxt.rdata = rdVal;
      end

      // register writes
      if (wrAcc && paddr == ADDR_TEST_MODE) begin
         st_nxt.usb_test_mode_control = pwdata[7:0] & ~(8'h01 << TM_LOOPBACK);
         st_nxt.loopbackPulse = pwdata[TM_LOOPBACK];
      end
      if (wrAcc && paddr == ADDR_TX_MAXP) begin
         st_nxt.payload = (pwdata[10:0] > PAYLOAD_MAX) ? PAYLOAD_MAX : pwdata[10:0];
      end
      if (wrAcc && paddr == ADDR_INT_ENABLE) begin
         st_nxt.irqEnable = pwdata[IRQ_W-1:0];
      end

      // host role override, latched for the whole session
      if (!coreIn.sessionOn) begin
         st_nxt.forcedHost = 1'b0;
         st_nxt.hostRole   = 1'b0;
      end else if (st_r.usb_test_mode_control[TM_HOST_FORCE] || st_r.forcedHost) begin
         st_nxt.forcedHost = 1'b1;
         st_nxt.hostRole   = 1'b1;
      end else begin
         st_nxt.hostRole   = coreIn.hostDetected;
      end

      // speed selection
      if (st_r.usb_test_mode_control[TM_SE0_NAK]) begin
         st_nxt.speed = SPD_HIGH;
      end else if (st_r.forcedHost || coreIn.busReset) begin
         if (st_r.usb_test_mode_control[TM_HS_OVERRIDE]) begin
            st_nxt.speed = SPD_HIGH;
         end else if (st_r.usb_test_mode_control[TM_FS_OVERRIDE]) begin
            st_nxt.speed = SPD_FULL;
         end else if (coreIn.busReset && !st_r.forcedHost) begin
            st_nxt.speed = coreIn.hsDetected ? SPD_HIGH : SPD_FULL;
         end
      end

      // NAK every valid IN while in SE0/NAK test
      st_nxt.nakPulse = st_r.usb_test_mode_control[TM_SE0_NAK] && coreIn.inToken;

      // test packet byte counter, restarts the packet every 53 bytes
      if (!st_r.usb_test_mode_control[TM_TEST_PACKET]) begin
         st_nxt.byteCount = 6'h00;
      end else if (coreIn.testByteTaken) begin
         if (st_r.byteCount == TEST_PACKET_BYTES - 6'h01) begin
            st_nxt.byteCount    = 6'h00;
            st_nxt.restartPulse = 1'b1;
         end else begin
            st_nxt.byteCount = st_r.byteCount + 6'h01;
         end
      end

      // control endpoint: clears first, sets after, except the hardware clears of stallReq and lastData, which come last
      if (coreIn.packetSent && st_r.txLoaded) begin
         st_nxt.txLoaded = 1'b0;
      end
      if (csrWr && pwdata[CS_RX_ACK]) begin
         st_nxt.rxPresent = 1'b0;
         if (pwdata[CS_LAST_DATA]) begin
            st_nxt.lastData = 1'b1;
         end
      end
      if (csrWr && pwdata[CS_EARLY_ACK]) begin
         st_nxt.earlyEnd = 1'b0;
      end
      if (csrWr && !pwdata[CS_STALL_SENT]) begin
         st_nxt.stallSentFlag = 1'b0;
      end
      if (csrWr && pwdata[CS_FLUSH] && (st_r.txLoaded || st_r.rxPresent)) begin
         st_nxt.txLoaded   = 1'b0;
         st_nxt.rxPresent  = 1'b0;
         st_nxt.flushPulse = 1'b1;
      end
      if (csrWr && pwdata[CS_TX_LOADED]) begin
         st_nxt.txLoaded = 1'b1;
         if (pwdata[CS_LAST_DATA]) begin
            st_nxt.lastData = 1'b1;
         end
      end
      if (csrWr && pwdata[CS_STALL_REQ]) begin
         st_nxt.stallReq = 1'b1;
      end
      if (coreIn.stallSent && st_r.stallReq) begin
         st_nxt.stallReq      = 1'b0;
         st_nxt.stallSentFlag = 1'b1;
      end
      if (coreIn.controlEnded) begin
         st_nxt.lastData = 1'b0;
         if (!st_r.lastData) begin
            st_nxt.earlyEnd   = 1'b1;
            st_nxt.flushPulse = 1'b1;
         end
      end
      if (coreIn.packetReceived) begin
         st_nxt.rxPresent = 1'b1;
      end

      // interrupt status: clear by write-one, a same-cycle event wins
      if (wrAcc && paddr == ADDR_INT_CLEAR) begin
         st_nxt.irqStatus = st_r.irqStatus & ~pwdata[IRQ_W-1:0];
      end
      if (coreIn.packetSent && st_r.txLoaded) begin
         st_nxt.irqStatus[IRQ_TX_DONE] = 1'b1;
      end
      if (coreIn.packetReceived) begin
         st_nxt.irqStatus[IRQ_RX_ARRIVED] = 1'b1;
      end
      if (coreIn.controlEnded && !st_r.lastData) begin
         st_nxt.irqStatus[IRQ_EARLY_END] = 1'b1;
      end
      if (coreIn.stallSent && st_r.stallReq) begin
         st_nxt.irqStatus[IRQ_STALL_SENT] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '{usb_test_mode_control: TEST_MODE_RESET, speed: SPD_FULL, payload: PAYLOAD_RESET,
                   irqStatus: IRQ_RESET, irqEnable: IRQ_RESET, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign irq    = |(st_r.irqStatus & st_r.irqEnable);

   always_comb begin
      coreOut.hostRole          = st_r.hostRole;
      coreOut.highSpeed         = st_r.speed == SPD_HIGH;
      coreOut.loopbackCopy      = st_r.loopbackPulse;
      coreOut.fifoFlush         = st_r.flushPulse;
      coreOut.testPacketOn      = st_r.usb_test_mode_control[TM_TEST_PACKET];
      coreOut.testPacketRestart = st_r.restartPulse;
      coreOut.driveK            = st_r.usb_test_mode_control[TM_DRIVE_K];
      coreOut.driveJ            = st_r.usb_test_mode_control[TM_DRIVE_J];
      coreOut.nakAnswer         = st_r.nakPulse;
      coreOut.stallHandshake    = st_r.stallReq;
      coreOut.payloadLimit      = st_r.payload;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_host_force;
      coreIn.sessionOn && st_r.usb_test_mode_control[TM_HOST_FORCE] ##1 coreIn.sessionOn |=> coreOut.hostRole;
   endproperty
   a_host_force: assert property (p_host_force) else $error("forced host not entered");

   property p_host_hold;
      coreOut.hostRole && st_r.forcedHost && coreIn.sessionOn && !coreIn.hostDetected |=> coreOut.hostRole;
   endproperty
   a_host_hold: assert property (p_host_hold) else $error("forced host dropped in session");

   property p_host_reenter;
      !coreIn.sessionOn ##1 coreIn.sessionOn && st_r.usb_test_mode_control[TM_HOST_FORCE] |=> st_r.forcedHost;
   endproperty
   a_host_reenter: assert property (p_host_reenter) else $error("forced host not re-entered");

   property p_loopback;
      wrAcc && paddr == ADDR_TEST_MODE && pwdata[TM_LOOPBACK] |=> coreOut.loopbackCopy ##1 !coreOut.loopbackCopy;
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback pulse wrong");

   property p_speed_hs;
      coreIn.busReset && st_r.usb_test_mode_control[TM_HS_OVERRIDE] |=> coreOut.highSpeed;
   endproperty
   a_speed_hs: assert property (p_speed_hs) else $error("high speed not forced");

   property p_speed_fs;
      coreIn.busReset && st_r.usb_test_mode_control[TM_FS_OVERRIDE] && !st_r.usb_test_mode_control[TM_HS_OVERRIDE]
         && !st_r.usb_test_mode_control[TM_SE0_NAK] |=> !coreOut.highSpeed;
   endproperty
   a_speed_fs: assert property (p_speed_fs) else $error("full speed not forced");

   property p_nak;
      st_r.usb_test_mode_control[TM_SE0_NAK] && coreIn.inToken |=> coreOut.nakAnswer && coreOut.highSpeed;
   endproperty
   a_nak: assert property (p_nak) else $error("IN not NAKed in high speed");

   property p_payload;
      coreOut.payloadLimit <= PAYLOAD_MAX;
   endproperty
   a_payload: assert property (p_payload) else $error("payload limit above 1024");

   property p_rx_present;
      coreIn.packetReceived |=> st_r.rxPresent && st_r.irqStatus[IRQ_RX_ARRIVED];
   endproperty
   a_rx_present: assert property (p_rx_present) else $error("rx arrival lost");

   property p_early_end;
      coreIn.controlEnded && !st_r.lastData |=> st_r.earlyEnd && coreOut.fifoFlush;
   endproperty
   a_early_end: assert property (p_early_end) else $error("early end not flagged");

   property p_stall;
      coreIn.stallSent && st_r.stallReq |=> !coreOut.stallHandshake && st_r.stallSentFlag;
   endproperty
   a_stall: assert property (p_stall) else $error("stall completion wrong");

   property p_tx_done;
      coreIn.packetSent && st_r.txLoaded && !csrWr |=> !st_r.txLoaded && st_r.irqStatus[IRQ_TX_DONE];
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("tx loaded not cleared");
endmodule
`default_nettype wire

// ---- tb/utmc_core_model.sv ----
/*
 * utmc_core_model: stand-in for the controller core and the far bus party.
 * assumes bench commands arrive as a core-input struct on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module utmc_core_model
   import utmc_pkg::*;
#(
   parameter int STALL_WAIT = 3
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // bench commands and core outputs
   input  wire utmc_core_in_type  cmd,
   input  wire utmc_core_out_type coreOut,
   // events into the block, observed packet length
   output utmc_core_in_type       coreIn,
   output logic [6:0]             pktBytes
);
   logic [3:0] stallCnt;
   logic       stallDone;
   logic       stallPulse;
   logic       byteTick;
   logic [6:0] byteCnt;

   always_comb begin
      coreIn               = cmd;
      coreIn.stallSent     = stallPulse;
      coreIn.testByteTaken = byteTick;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stallCnt   <= 4'h0;
         stallDone  <= 1'b0;
         stallPulse <= 1'b0;
         byteTick   <= 1'b0;
         byteCnt    <= 7'h00;
         pktBytes   <= 7'h00;
      end else begin
         stallPulse <= 1'b0;
         // handshake goes out a few cycles late, once per request
         if (!coreOut.stallHandshake) begin
            stallCnt  <= 4'h0;
            stallDone <= 1'b0;
         end else if (!stallDone) begin
            stallCnt <= stallCnt + 4'h1;
            if (stallCnt == STALL_WAIT[3:0]) begin
               stallPulse <= 1'b1;
               stallDone  <= 1'b1;
            end
         end
         // slow line: one test byte every other cycle
         byteTick <= coreOut.testPacketOn & ~byteTick;
         if (coreOut.testPacketRestart) begin
            pktBytes <= byteCnt;
            byteCnt  <= {6'h00, byteTick};
         end else if (byteTick) begin
            byteCnt <= byteCnt + 7'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/utmc_test_mode_ctrl_tb.sv ----
/*
 * utmc_test_mode_ctrl_tb: APB register and core-event tests of the block.
 * assumes the core model answers stall requests and test-byte requests.
 */
`timescale 1ns/1ps
`default_nettype none
module utmc_test_mode_ctrl_tb
   import utmc_pkg::*;
;
   localparam int B_RST  = 7;
   localparam int B_SENT = 5;
   localparam int B_RCV  = 4;
   localparam int B_END  = 3;
   localparam int B_IN   = 1;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   utmc_core_in_type  cmd = '0;
   utmc_core_in_type  coreIn;
   utmc_core_out_type coreOut;
   logic              irq;
   logic [6:0]        pktBytes;
   logic [31:0]       rdData;
   logic              rdErr;
   int                mismatches = 0;
   int                tests_run = 0;
   int                cycles = 0;
   int                n;

   utmc_test_mode_ctrl i_utmc_test_mode_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .coreIn(coreIn), .coreOut(coreOut), .irq(irq));
   utmc_core_model i_utmc_core_model (.clk(clk), .rst_n(rst_n), .cmd(cmd), .coreOut(coreOut),
      .coreIn(coreIn), .pktBytes(pktBytes));

   always #5 clk = ~clk;

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
      apb(1'b0, a, 32'h0);
      chk(rdData, exp, m);
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      cmd[b] <= 1'b1;
      @(posedge clk);
      cmd[b] <= 1'b0;
      #1;
   endtask
   task automatic sess(input logic v);
      @(posedge clk);
      cmd.sessionOn <= v;
      repeat (2) @(posedge clk);
      #1;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_TEST_MODE, 32'h0, "test mode reset");
      rd(ADDR_TX_MAXP, 32'h0, "payload reset");
      rd(ADDR_EP0_CSR, 32'h0, "csr reset");
      rd(ADDR_INT_ENABLE, 32'h0, "enable reset");
      rd(8'h20, 32'h0, "unmapped read");
      chk(rdErr, 32'h1, "unmapped error");
      $display("test reset done");
      wr(ADDR_TEST_MODE, 32'h80);
      chk(coreOut.hostRole, 32'h0, "host without session");
      sess(1'b1);
      chk(coreOut.hostRole, 32'h1, "forced host");
      sess(1'b0);
      chk(coreOut.hostRole, 32'h0, "host left at session end");
      sess(1'b1);
      chk(coreOut.hostRole, 32'h1, "host re-entered");
      wr(ADDR_TEST_MODE, 32'h90);
      // speed follows the override bits one cycle after the write lands
      @(posedge clk);
      #1;
      chk(coreOut.highSpeed, 32'h1, "forced host high speed");
      wr(ADDR_TEST_MODE, 32'hA0);
      @(posedge clk);
      #1;
      chk(coreOut.highSpeed, 32'h0, "forced host full speed");
      sess(1'b0);
      wr(ADDR_TEST_MODE, 32'h00);
      sess(1'b1);
      chk(coreOut.hostRole, 32'h0, "no host without override");
      sess(1'b0);
      $display("test host role done");
      wr(ADDR_TEST_MODE, 32'h10);
      pulse(B_RST);
      chk(coreOut.highSpeed, 32'h1, "high speed after bus reset");
      @(posedge clk);
      cmd.hsDetected <= 1'b1;
      wr(ADDR_TEST_MODE, 32'h20);
      pulse(B_RST);
      chk(coreOut.highSpeed, 32'h0, "full speed after bus reset");
      wr(ADDR_TEST_MODE, 32'h04);
      chk({coreOut.driveK, coreOut.driveJ}, 32'h2, "K state");
      wr(ADDR_TEST_MODE, 32'h02);
      chk({coreOut.driveK, coreOut.driveJ}, 32'h1, "J state");
      wr(ADDR_TEST_MODE, 32'h01);
      pulse(B_IN);
      chk(coreOut.nakAnswer, 32'h1, "nak on in token");
      chk(coreOut.highSpeed, 32'h1, "se0 nak keeps high speed");
      wr(ADDR_TEST_MODE, 32'h40);
      chk(coreOut.loopbackCopy, 32'h1, "loopback pulse");
      @(posedge clk);
      #1;
      chk(coreOut.loopbackCopy, 32'h0, "loopback one cycle");
      rd(ADDR_TEST_MODE, 32'h0, "loopback reads zero");
      $display("test modes done");
      // tx packet loaded before the test packet mode starts
      wr(ADDR_EP0_CSR, 32'h2);
      wr(ADDR_TEST_MODE, 32'h08);
      chk(coreOut.testPacketOn, 32'h1, "test packet on");
      for (int i = 0; i < 2; i++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (coreOut.testPacketRestart !== 1'b1 && n < 400);
         chk(n < 400, 32'h1, "test packet restart seen");
      end
      @(posedge clk);
      #1;
      chk(pktBytes, {1'b0, TEST_PACKET_BYTES}, "test packet length");
      wr(ADDR_TEST_MODE, 32'h0);
      wr(ADDR_TX_MAXP, 32'h7FF);
      rd(ADDR_TX_MAXP, 32'h400, "payload clamp");
      chk(coreOut.payloadLimit, 32'h400, "payload to core");
      wr(ADDR_TX_MAXP, 32'hFFFF_0040);
      rd(ADDR_TX_MAXP, 32'h40, "payload reserved bits");
      $display("test payload done");
      wr(ADDR_INT_ENABLE, 32'hF);
      pulse(B_SENT);
      rd(ADDR_EP0_CSR, 32'h0, "tx loaded cleared");
      rd(ADDR_INT_STATUS, 32'h1, "tx done status");
      chk(irq, 32'h1, "tx done irq");
      wr(ADDR_INT_CLEAR, 32'hF);
      chk(irq, 32'h0, "irq cleared");
      wr(ADDR_INT_ENABLE, 32'h0);
      pulse(B_RCV);
      rd(ADDR_EP0_CSR, 32'h1, "rx present");
      chk(irq, 32'h0, "irq masked");
      rd(ADDR_INT_STATUS, 32'h2, "rx status");
      wr(ADDR_INT_ENABLE, 32'hF);
      chk(irq, 32'h1, "irq unmasked");
      wr(ADDR_EP0_CSR, 32'h40);
      rd(ADDR_EP0_CSR, 32'h0, "rx ack");
      wr(ADDR_INT_CLEAR, 32'hF);
      pulse(B_END);
      chk(coreOut.fifoFlush, 32'h1, "early end flush");
      rd(ADDR_EP0_CSR, 32'h10, "early end flag");
      rd(ADDR_INT_STATUS, 32'h4, "early end status");
      wr(ADDR_EP0_CSR, 32'h80);
      rd(ADDR_EP0_CSR, 32'h0, "early end ack");
      wr(ADDR_EP0_CSR, 32'hA);
      pulse(B_END);
      rd(ADDR_EP0_CSR, 32'h2, "no early end after last data");
      pulse(B_SENT);
      wr(ADDR_INT_CLEAR, 32'hF);
      wr(ADDR_EP0_CSR, 32'h20);
      chk(coreOut.stallHandshake, 32'h1, "stall pending");
      n = 0;
      while (coreOut.stallHandshake !== 1'b0 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n < 50, 32'h1, "stall sent in time");
      rd(ADDR_EP0_CSR, 32'h4, "stall sent flag");
      rd(ADDR_INT_STATUS, 32'h8, "stall status");
      wr(ADDR_INT_STATUS, 32'h0);
      rd(ADDR_INT_STATUS, 32'h8, "status write ignored");
      rd(ADDR_INT_CLEAR, 32'h0, "clear reads zero");
      wr(ADDR_EP0_CSR, 32'h4);
      rd(ADDR_EP0_CSR, 32'h4, "stall flag kept by one");
      wr(ADDR_EP0_CSR, 32'h0);
      rd(ADDR_EP0_CSR, 32'h0, "stall flag cleared");
      wr(ADDR_EP0_CSR, 32'h100);
      chk(coreOut.fifoFlush, 32'h0, "flush ignored when empty");
      wr(ADDR_EP0_CSR, 32'h2);
      wr(ADDR_EP0_CSR, 32'h100);
      chk(coreOut.fifoFlush, 32'h1, "flush pulse");
      rd(ADDR_EP0_CSR, 32'h0, "flush clears tx loaded");
      $display("test control endpoint done");
      // reset in mid-run drops modes and pending interrupts
      wr(ADDR_TEST_MODE, 32'h04);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk({coreOut.driveK, irq}, 32'h0, "mid-run reset clears");
      rd(ADDR_TEST_MODE, 32'h0, "test mode after reset");
      $display("test mid-run reset done");
      stop_test();
   end
endmodule
`default_nettype wire
